/* File: logic/hmbx_pkg.sv */
/*
  Package of the host mailbox status block: register selects, bit
  positions, reset values and the carrier types shared by the design.
  Assumes both processors reach the block through the select codes
  below and that each access is a single-cycle strobe.
*/
// Summary of operation
// RULE_01 - Channel-two output-full is status bit 0, resets 0, set while data uncollected.
// RULE_02 - A slave write of channel-two output data sets channel-two output-full.
// RULE_03 - Host read of channel-two output data, or slave writing 0, clears it.
// RULE_04 - A slave read of channel-two input data clears channel-two input-full.
// RULE_05 - A host write of channel-two input data sets channel-two input-full.
// RULE_06 - Slave-writable output-full flags accept only 0; writing 1 leaves them unchanged.
// RULE_07 - Status three shows the bidirectional layout when enabled or layout select is 0.
// RULE_08 - Bidirectional input-full is status three bit 7, resets 0, interrupts the slave.
// RULE_09 - Host write of bidirectional register 15 sets it; slave read clears it.
// RULE_10 - Bidirectional output-full is status three bit 6, resets 0.
// RULE_11 - A slave write of bidirectional register 15 sets bidirectional output-full.
// RULE_12 - Host read of register 15, or slave writing 0, clears bidirectional output-full.
// RULE_13 - Read-only host block write mode flag is status three bit 5, resets 0.
// RULE_14 - Host write of register 0 sets it when slave mode is 0; slave reads 15 clear.
// RULE_15 - Channel-two input-full is status bit 1 and interrupts the slave.
// RULE_16 - Host write to channel-two input captures address bit 2 into status bit 3.
// RULE_17 - Host status accesses are read-only; reads never alter any flag.

`default_nettype none

package hmbx_pkg;

  // ----------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------
  localparam logic [4:0] SEL_BIDIR_FIRST = 5'h00;
  localparam logic [4:0] SEL_BIDIR_LAST  = 5'h0F;
  localparam logic [4:0] SEL_C2_DATA     = 5'h10;
  localparam logic [4:0] SEL_C2_STATUS   = 5'h11;
  localparam logic [4:0] SEL_BI_STATUS   = 5'h12;
  localparam logic [4:0] SEL_CONTROL     = 5'h13;

  // ----------------------------------------------------------------
  // Bit positions and reset values
  // ----------------------------------------------------------------
  localparam int C2_OUT_FULL_BIT = 0;
  localparam int C2_IN_FULL_BIT  = 1;
  localparam int C2_CMD_BIT      = 3;
  localparam int BI_IN_FULL_BIT  = 7;
  localparam int BI_OUT_FULL_BIT = 6;
  localparam int HOST_MODE_BIT   = 5;
  localparam int SLAVE_MODE_BIT  = 4;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LAYOUT_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] sel;
    logic       io_a2;
    logic [7:0] data;
  } hmbx_hwr_t;

  typedef struct packed {
    logic c2_in_full;
    logic c2_out_full;
    logic c2_cmd;
    logic bi_in_full;
    logic bi_out_full;
    logic host_mode;
  } hmbx_flags_t;

endpackage : hmbx_pkg

`default_nettype wire

/* File: logic/hmbx_top.sv */
/*
  Host mailbox status block: channel-two data and status, sixteen
  bidirectional data registers with their status, a write FIFO for
  host write cycles.
  Assumes host and slave strobes are synchronous to mclk, one cycle
  long, and that the slave write mode flag comes from outside.
*/
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Host write FIFO
// ------------------------------------------------------------------
module hmbx_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and control.
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Filling side.
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0]  mem [DEPTH];
  logic [AW-1:0]     wptr_q;
  logic [AW-1:0]     rptr_q;
  logic [AW:0]       count_q;
  logic [AW:0]       count_d;
  logic              push;
  logic              pop;

  // Refused at elaboration: the pointers only wrap cleanly at a power of two.
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("hmbx_fifo: DEPTH must be a power of two, at least 2.");
  end

  // Handshakes on both sides; ready is a flop so it never glitches.
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rptr_q];
  assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);

  // Storage is written without reset; only pointers, count and ready need a value.
  always_ff @(posedge mclk)
  begin
    if (ce && push)
      mem[wptr_q] <= in_data;
  end

  // Pointers, fill count and the registered ready.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wptr_q   <= '0;
      rptr_q   <= '0;
      count_q  <= '0;
      in_ready <= 1'b1;
    end
    else if (ce)
    begin
      if (push)
        wptr_q <= wptr_q + AW'(1);
      if (pop)
        rptr_q <= rptr_q + AW'(1);
      count_q  <= count_d;
      in_ready <= (count_d != (AW+1)'(DEPTH));
    end
  end
endmodule : hmbx_fifo

// ------------------------------------------------------------------
// Mailbox top
// ------------------------------------------------------------------
module hmbx_top #(
  parameter int FIFO_WORDS = hmbx_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable.
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Host write cycles, queued.
  input  wire logic                host_wr_valid,
  output var  logic                host_wr_ready,
  input  wire hmbx_pkg::hmbx_hwr_t host_wr,
  // Host read cycles.
  input  wire logic                host_rd,
  input  wire logic [4:0]          host_rd_sel,
  output var  logic [7:0]          host_rdata_q,
  // Slave processor accesses.
  input  wire logic                slv_wr,
  input  wire logic                slv_rd,
  input  wire logic [4:0]          slv_sel,
  input  wire logic [7:0]          slv_wdata,
  output var  logic [7:0]          slv_rdata_q,
  // Slave write mode flag from the block that owns it.
  input  wire logic                slave_block_write_mode,
  // Status and interrupt requests to the slave.
  output var  logic [7:0]          channel_two_status_q,
  output var  logic [7:0]          bidirectional_channel_status_q,
  output var  logic                c2_input_irq_q,
  output var  logic                bidir_input_irq_q
);
  import hmbx_pkg::*;

  hmbx_flags_t f_q;
  hmbx_flags_t f_d;
  hmbx_hwr_t   hw;
  logic        hw_valid;
  logic        drain_rdy;
  logic        hw_go;
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic [7:0]  c2_in_data_q;
  logic [7:0]  c2_out_data_q;
  logic [7:0]  bidir_q [16];

  // Refused at elaboration; the queue checks the power-of-two rule itself.
  if (FIFO_WORDS < 2)
  begin : g_bad_words
    $error("hmbx_top: FIFO_WORDS must be at least 2.");
  end

  // ----------------------------------------------------------------
  // Status composition
  // ----------------------------------------------------------------
  function automatic logic [7:0] st2(input hmbx_flags_t f);
    logic [7:0] v;
    v = RESET_BYTE;
    v[C2_OUT_FULL_BIT] = f.c2_out_full; // RULE_01
    v[C2_IN_FULL_BIT]  = f.c2_in_full;  // RULE_15
    v[C2_CMD_BIT]      = f.c2_cmd;
    return v;
  endfunction : st2

  function automatic logic [7:0] st3(input hmbx_flags_t f, input logic [1:0] c,
                                     input logic swm);
    logic [7:0] v;
    v = RESET_BYTE;
    // Other layout belongs to another channel and reads as zero here.
    if (c[CTRL_ENABLE_BIT] || !c[CTRL_LAYOUT_BIT]) // RULE_07
    begin
      v[BI_IN_FULL_BIT]  = f.bi_in_full;  // RULE_08
      v[BI_OUT_FULL_BIT] = f.bi_out_full; // RULE_10
      v[HOST_MODE_BIT]   = f.host_mode;   // RULE_13
      v[SLAVE_MODE_BIT]  = swm;
    end
    return v;
  endfunction : st3

  // ----------------------------------------------------------------
  // Host write queue
  // ----------------------------------------------------------------
  // The slave wins the register file; host writes wait in the FIFO.
  assign drain_rdy = !(slv_wr || slv_rd);
  assign hw_go     = hw_valid && drain_rdy;

  hmbx_fifo #(
    .WIDTH ($bits(hmbx_hwr_t)),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (host_wr_valid),
    .in_ready  (host_wr_ready),
    .in_data   (host_wr),
    .out_valid (hw_valid),
    .out_ready (drain_rdy),
    .out_data  (hw)
  );

  // ----------------------------------------------------------------
  // Flag next state; every set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    f_d = f_q;
    // Channel-two output side.
    if ((host_rd && host_rd_sel == SEL_C2_DATA) ||
        (slv_wr && slv_sel == SEL_C2_STATUS && !slv_wdata[C2_OUT_FULL_BIT])) // RULE_06
      f_d.c2_out_full = 1'b0; // RULE_03
    if (slv_wr && slv_sel == SEL_C2_DATA)
      f_d.c2_out_full = 1'b1; // RULE_02
    // Channel-two input side.
    if (slv_rd && slv_sel == SEL_C2_DATA)
      f_d.c2_in_full = 1'b0; // RULE_04
    if (hw_go && hw.sel == SEL_C2_DATA)
    begin
      f_d.c2_in_full = 1'b1;     // RULE_05
      f_d.c2_cmd     = hw.io_a2; // RULE_16
    end
    // Bidirectional input side and host block write mode.
    if (slv_rd && slv_sel == SEL_BIDIR_LAST)
    begin
      f_d.bi_in_full = 1'b0; // RULE_09
      f_d.host_mode  = 1'b0; // RULE_14
    end
    if (hw_go && hw.sel == SEL_BIDIR_LAST)
      f_d.bi_in_full = 1'b1; // RULE_09
    if (hw_go && hw.sel == SEL_BIDIR_FIRST && !slave_block_write_mode)
      f_d.host_mode = 1'b1; // RULE_14
    // Bidirectional output side.
    if ((host_rd && host_rd_sel == SEL_BIDIR_LAST) ||
        (slv_wr && slv_sel == SEL_BI_STATUS && !slv_wdata[BI_OUT_FULL_BIT])) // RULE_06
      f_d.bi_out_full = 1'b0; // RULE_12
    if (slv_wr && slv_sel == SEL_BIDIR_LAST)
      f_d.bi_out_full = 1'b1; // RULE_11
    // Host writes to status selects fall through untouched.
  end

  assign ctrl_d = (slv_wr && slv_sel == SEL_CONTROL) ?
                  slv_wdata[1:0] : ctrl_q;

  // ----------------------------------------------------------------
  // Flags, control and status outputs
  // ----------------------------------------------------------------
  // Outputs are loaded from next values so they always match the flags.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      f_q                            <= '0;
      ctrl_q                         <= '0;
      channel_two_status_q           <= RESET_BYTE;
      bidirectional_channel_status_q <= RESET_BYTE;
      c2_input_irq_q                 <= 1'b0;
      bidir_input_irq_q              <= 1'b0;
    end
    else if (ce)
    begin
      f_q                            <= f_d;
      ctrl_q                         <= ctrl_d;
      channel_two_status_q           <= st2(f_d);
      bidirectional_channel_status_q <= st3(f_d, ctrl_d, slave_block_write_mode);
      c2_input_irq_q                 <= f_d.c2_in_full; // RULE_15
      bidir_input_irq_q              <= f_d.bi_in_full; // RULE_08
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Both processors share the bidirectional bytes; the slave has the port
  // in any cycle it accesses, so they never collide.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      c2_in_data_q  <= RESET_BYTE;
      c2_out_data_q <= RESET_BYTE;
      for (int i = 0; i < 16; i++)
        bidir_q[i] <= RESET_BYTE;
    end
    else if (ce)
    begin
      if (hw_go && hw.sel == SEL_C2_DATA)
        c2_in_data_q <= hw.data;
      if (slv_wr && slv_sel == SEL_C2_DATA)
        c2_out_data_q <= slv_wdata;
      if (hw_go && hw.sel <= SEL_BIDIR_LAST)
        bidir_q[hw.sel[3:0]] <= hw.data;
      if (slv_wr && slv_sel <= SEL_BIDIR_LAST)
        bidir_q[slv_sel[3:0]] <= slv_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      host_rdata_q <= RESET_BYTE;
      slv_rdata_q  <= RESET_BYTE;
    end
    else if (ce)
    begin
      if (host_rd)
      begin
        if (host_rd_sel <= SEL_BIDIR_LAST)
          host_rdata_q <= bidir_q[host_rd_sel[3:0]];
        else if (host_rd_sel == SEL_C2_DATA)
          host_rdata_q <= c2_out_data_q;
        else if (host_rd_sel == SEL_C2_STATUS)
          host_rdata_q <= st2(f_q); // RULE_17
        else if (host_rd_sel == SEL_BI_STATUS)
          host_rdata_q <= st3(f_q, ctrl_q, slave_block_write_mode);
        else
          host_rdata_q <= RESET_BYTE;
      end
      if (slv_rd)
      begin
        if (slv_sel <= SEL_BIDIR_LAST)
          slv_rdata_q <= bidir_q[slv_sel[3:0]];
        else if (slv_sel == SEL_C2_DATA)
          slv_rdata_q <= c2_in_data_q;
        else if (slv_sel == SEL_C2_STATUS)
          slv_rdata_q <= st2(f_q);
        else if (slv_sel == SEL_BI_STATUS)
          slv_rdata_q <= st3(f_q, ctrl_q, slave_block_write_mode);
        else if (slv_sel == SEL_CONTROL)
          slv_rdata_q <= {6'h00, ctrl_q};
        else
          slv_rdata_q <= RESET_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_host_fill_last;
    ce && hw_go && hw.sel == SEL_BIDIR_LAST;
  endsequence

  sequence s_slave_drain_last;
    ce && slv_rd && slv_sel == SEL_BIDIR_LAST;
  endsequence

  property p_c2_out_set;
    @(posedge mclk) disable iff (rst)
    ce && slv_wr && slv_sel == SEL_C2_DATA |=> channel_two_status_q[0];
  endproperty
  a_c2_out_set: assert property (p_c2_out_set) else $error("c2 out-full not set."); // RULE_02

  property p_c2_out_clr;
    @(posedge mclk) disable iff (rst)
    ce && host_rd && host_rd_sel == SEL_C2_DATA && !slv_wr |=> !f_q.c2_out_full;
  endproperty
  a_c2_out_clr: assert property (p_c2_out_clr) else $error("c2 out-full not cleared."); // RULE_03

  property p_write_one_keeps;
    @(posedge mclk) disable iff (rst)
    ce && slv_wr && slv_sel == SEL_C2_STATUS && slv_wdata[0] && !host_rd
      |=> $stable(f_q.c2_out_full);
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("Write of 1 moved flag."); // RULE_06

  property p_c2_in_clr;
    @(posedge mclk) disable iff (rst)
    ce && slv_rd && slv_sel == SEL_C2_DATA |=> !c2_input_irq_q;
  endproperty
  a_c2_in_clr: assert property (p_c2_in_clr) else $error("c2 in-full not cleared."); // RULE_04

  property p_c2_in_set;
    @(posedge mclk) disable iff (rst)
    ce && hw_go && hw.sel == SEL_C2_DATA
      |=> channel_two_status_q[1] && channel_two_status_q[3] == $past(hw.io_a2);
  endproperty
  a_c2_in_set: assert property (p_c2_in_set) else $error("c2 in-full or cmd wrong."); // RULE_05

  property p_bi_in;
    @(posedge mclk) disable iff (rst)
    (s_host_fill_last |=> bidir_input_irq_q ##1 1'b1) and
    (s_slave_drain_last |=> !f_q.bi_in_full && !f_q.host_mode);
  endproperty
  a_bi_in: assert property (p_bi_in) else $error("Bidir in-full sequence wrong."); // RULE_09

  property p_bi_out;
    @(posedge mclk) disable iff (rst)
    ce && slv_wr && slv_sel == SEL_BIDIR_LAST |=> f_q.bi_out_full;
  endproperty
  a_bi_out: assert property (p_bi_out) else $error("Bidir out-full not set."); // RULE_11

  property p_bi_out_clr;
    @(posedge mclk) disable iff (rst)
    ce && host_rd && host_rd_sel == SEL_BIDIR_LAST && !slv_wr |=> !f_q.bi_out_full;
  endproperty
  a_bi_out_clr: assert property (p_bi_out_clr) else $error("Bidir out-full not cleared."); // RULE_12

  property p_host_mode;
    @(posedge mclk) disable iff (rst)
    ce && hw_go && hw.sel == SEL_BIDIR_FIRST && !slave_block_write_mode |=> f_q.host_mode;
  endproperty
  a_host_mode: assert property (p_host_mode) else $error("Host mode not set."); // RULE_14

  property p_layout;
    @(posedge mclk) disable iff (rst)
    (ctrl_q[0] || !ctrl_q[1]) |-> bidirectional_channel_status_q[7:5] ==
      {f_q.bi_in_full, f_q.bi_out_full, f_q.host_mode};
  endproperty
  a_layout: assert property (p_layout) else $error("Status three layout wrong."); // RULE_07

  property p_status_ro;
    @(posedge mclk) disable iff (rst)
    ce && hw_go && (hw.sel == SEL_C2_STATUS || hw.sel == SEL_BI_STATUS) && drain_rdy
      && !host_rd |=> $stable(f_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("Host status write moved flags."); // RULE_17
endmodule : hmbx_top

`default_nettype wire

/* File: testbench/hmbx_host_model.sv */
/*
  Host processor model for the mailbox status block: queued I/O write
  cycles and single I/O read cycles, both commanded by the testbench.
  Assumes one clock, mclk, and the select map of the block's package.
*/
`timescale 1ns/10ps
`default_nettype none

module hmbx_host_model (
  // Clock.
  input  wire logic                mclk,
  // Write queue.
  output var  logic                host_wr_valid,
  input  wire logic                host_wr_ready,
  output var  hmbx_pkg::hmbx_hwr_t host_wr,
  // Read cycles.
  output var  logic                host_rd,
  output var  logic [4:0]          host_rd_sel,
  input  wire logic [7:0]          host_rdata_q
);
  import hmbx_pkg::*;

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // The bus starts idle so no cycle is seen before reset ends.
  initial
  begin
    host_wr_valid = 1'b0;
    host_wr       = '0;
    host_rd       = 1'b0;
    host_rd_sel   = 5'h1F;
  end

  // ----------------------------------------------------------------
  // Cycles
  // ----------------------------------------------------------------
  // Write cycle; held until ready is sampled high at an edge, or for at most 64 more edges.
  task automatic write_cycle(input logic [4:0] sel, input logic a2, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge mclk);
    host_wr_valid <= 1'b1;
    host_wr       <= '{sel: sel, io_a2: a2, data: data};
    @(posedge mclk);
    while (host_wr_ready !== 1'b1 && n < 64)
    begin
      @(posedge mclk);
      n++;
    end
    // Released lines show the inverse, so stale data never looks live.
    host_wr_valid <= 1'b0;
    host_wr       <= ~host_wr;
  endtask : write_cycle

  // Read cycle; the data is taken one cycle after the strobe.
  task automatic read_cycle(input logic [4:0] sel, output logic [7:0] data);
    @(posedge mclk);
    host_rd     <= 1'b1;
    host_rd_sel <= sel;
    @(posedge mclk);
    host_rd     <= 1'b0;
    host_rd_sel <= ~sel;
    #1;
    data = host_rdata_q;
  endtask : read_cycle

endmodule : hmbx_host_model
`default_nettype wire

/* File: testbench/hmbx_top_tb.sv */
/*
  Self-checking testbench of the host mailbox status block.
  Assumes the host model beside it and drives the slave side itself.
*/
`timescale 1ns/10ps
`default_nettype none

module hmbx_top_tb;
  import hmbx_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic                ce = 1'b1;
  logic                host_wr_valid;
  logic                host_wr_ready;
  hmbx_hwr_t           host_wr;
  logic                host_rd;
  logic [4:0]          host_rd_sel;
  logic [7:0]          host_rdata_q;
  logic                slv_wr = 1'b0;
  logic                slv_rd = 1'b0;
  logic [4:0]          slv_sel = 5'h1F;
  logic [7:0]          slv_wdata = 8'h00;
  logic [7:0]          slv_rdata_q;
  logic                swm = 1'b0;
  logic [7:0]          st2;
  logic [7:0]          st3;
  logic                irq2;
  logic                irq3;
  logic [7:0]          d;
  int                  miscompares = 0;
  int                  n_compared = 0;

  // Clock of 25 MHz.
  always #20 mclk = ~mclk;

  hmbx_top i_hmbx_top (
    .mclk(mclk), .rst(rst), .ce(ce), .host_wr_valid(host_wr_valid),
    .host_wr_ready(host_wr_ready), .host_wr(host_wr), .host_rd(host_rd),
    .host_rd_sel(host_rd_sel), .host_rdata_q(host_rdata_q), .slv_wr(slv_wr),
    .slv_rd(slv_rd), .slv_sel(slv_sel), .slv_wdata(slv_wdata), .slv_rdata_q(slv_rdata_q),
    .slave_block_write_mode(swm), .channel_two_status_q(st2),
    .bidirectional_channel_status_q(st3), .c2_input_irq_q(irq2), .bidir_input_irq_q(irq3)
  );

  hmbx_host_model i_hmbx_host_model (
    .mclk(mclk), .host_wr_valid(host_wr_valid), .host_wr_ready(host_wr_ready),
    .host_wr(host_wr), .host_rd(host_rd), .host_rd_sel(host_rd_sel),
    .host_rdata_q(host_rdata_q)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  function automatic logic [7:0] fb(input int b);
    return 8'h01 << b;
  endfunction : fb

  // One slave access; status and read data are settled on return.
  task automatic slave_op(input logic wr, input logic [4:0] sel, input logic [7:0] wdata);
    @(posedge mclk);
    slv_wr    <= wr;
    slv_rd    <= ~wr;
    slv_sel   <= sel;
    slv_wdata <= wdata;
    @(posedge mclk);
    slv_wr    <= 1'b0;
    slv_rd    <= 1'b0;
    slv_sel   <= ~sel;
    slv_wdata <= ~wdata;
    #1;
  endtask : slave_op

  // Host write, then two cycles; the queue applies it at the first of them.
  task automatic hw(input logic [4:0] sel, input logic a2, input logic [7:0] data);
    i_hmbx_host_model.write_cycle(sel, a2, data);
    repeat (2) @(posedge mclk);
    #1;
  endtask : hw

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset;
    check(st2, 8'h00);
    check(st3, 8'h00);
    check({7'h00, host_wr_ready}, 8'h01);
    check({6'h00, irq2, irq3}, 8'h00);
  endtask : sc_reset

  task automatic sc_c2_out;
    slave_op(1'b1, SEL_C2_DATA, 8'hA5);
    check(st2, fb(C2_OUT_FULL_BIT));
    slave_op(1'b1, SEL_C2_STATUS, 8'hFF);
    check(st2, fb(C2_OUT_FULL_BIT));
    hw(SEL_C2_STATUS, 1'b0, 8'h00);
    check(st2, fb(C2_OUT_FULL_BIT));
    i_hmbx_host_model.read_cycle(SEL_C2_STATUS, d);
    check(d, fb(C2_OUT_FULL_BIT));
    check(st2, fb(C2_OUT_FULL_BIT));
    i_hmbx_host_model.read_cycle(SEL_C2_DATA, d);
    check(d, 8'hA5);
    check(st2, 8'h00);
    slave_op(1'b1, SEL_C2_DATA, 8'h3C);
    slave_op(1'b1, SEL_C2_STATUS, 8'h00);
    check(st2, 8'h00);
  endtask : sc_c2_out

  task automatic sc_c2_in;
    hw(SEL_C2_DATA, 1'b1, 8'h5A);
    check(st2, fb(C2_IN_FULL_BIT) | fb(C2_CMD_BIT));
    check({7'h00, irq2}, 8'h01);
    slave_op(1'b0, SEL_C2_DATA, 8'h00);
    check(slv_rdata_q, 8'h5A);
    check(st2, fb(C2_CMD_BIT));
    hw(SEL_C2_DATA, 1'b0, 8'h00);
    check(st2, fb(C2_IN_FULL_BIT));
    slave_op(1'b0, SEL_C2_DATA, 8'h00);
    check(st2, 8'h00);
  endtask : sc_c2_in

  task automatic sc_bidir;
    // A frozen block must ignore the slave write.
    @(posedge mclk);
    ce <= 1'b0;
    slave_op(1'b1, SEL_BIDIR_LAST, 8'h77);
    check(st3, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    slave_op(1'b1, SEL_BIDIR_LAST, 8'h77);
    check(st3, fb(BI_OUT_FULL_BIT));
    slave_op(1'b1, SEL_BI_STATUS, 8'hFF);
    check(st3, fb(BI_OUT_FULL_BIT));
    i_hmbx_host_model.read_cycle(SEL_BIDIR_LAST, d);
    check(d, 8'h77);
    check(st3, 8'h00);
    slave_op(1'b1, SEL_BIDIR_LAST, 8'h01);
    slave_op(1'b1, SEL_BI_STATUS, 8'h00);
    check(st3, 8'h00);
    hw(SEL_BIDIR_FIRST, 1'b0, 8'h10);
    check(st3, fb(HOST_MODE_BIT));
    slave_op(1'b1, SEL_BI_STATUS, 8'h00);
    check(st3, fb(HOST_MODE_BIT));
    hw(SEL_BIDIR_LAST, 1'b0, 8'h1F);
    check(st3, fb(BI_IN_FULL_BIT) | fb(HOST_MODE_BIT));
    check({7'h00, irq3}, 8'h01);
    slave_op(1'b0, SEL_BIDIR_LAST, 8'h00);
    check(slv_rdata_q, 8'h1F);
    check(st3, 8'h00);
    @(posedge mclk);
    swm <= 1'b1;
    hw(SEL_BIDIR_FIRST, 1'b0, 8'h20);
    check(st3, fb(SLAVE_MODE_BIT));
    @(posedge mclk);
    swm <= 1'b0;
  endtask : sc_bidir

  task automatic sc_layout;
    logic [7:0] ctl [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
    slave_op(1'b1, SEL_BIDIR_LAST, 8'h22);
    foreach (ctl[i])
    begin
      slave_op(1'b1, SEL_CONTROL, ctl[i]);
      check(st3, (ctl[i] == 8'h02) ? 8'h00 : fb(BI_OUT_FULL_BIT));
    end
    slave_op(1'b1, SEL_CONTROL, 8'h00);
    i_hmbx_host_model.read_cycle(SEL_BIDIR_LAST, d);
    check(d, 8'h22);
    check(st3, 8'h00);
  endtask : sc_layout

  // Slave reads hold off the drain, so the queue fills and refuses.
  task automatic sc_fifo;
    @(posedge mclk);
    slv_rd  <= 1'b1;
    slv_sel <= SEL_CONTROL;
    for (int i = 0; i < 16; i++)
      i_hmbx_host_model.write_cycle(SEL_C2_DATA, i[0], 8'(i));
    repeat (2) @(posedge mclk);
    #1;
    check({7'h00, host_wr_ready}, 8'h00);
    check(st2, 8'h00);
    fork
      i_hmbx_host_model.write_cycle(SEL_C2_DATA, 1'b0, 8'h11);
      begin
        repeat (4) @(posedge mclk);
        #1;
        check({7'h00, host_wr_ready}, 8'h00);
        @(posedge mclk);
        slv_rd <= 1'b0;
      end
    join
    repeat (40) @(posedge mclk);
    #1;
    check({7'h00, host_wr_ready}, 8'h01);
    check(st2, fb(C2_IN_FULL_BIT));
    slave_op(1'b0, SEL_C2_DATA, 8'h00);
    check(slv_rdata_q, 8'h11);
  endtask : sc_fifo

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    sc_reset();
    sc_c2_out();
    sc_c2_in();
    sc_bidir();
    sc_layout();
    sc_fifo();
    complete_run();
  end

  // The whole run needs well under a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    complete_run();
  end

endmodule : hmbx_top_tb
`default_nettype wire
